// ---- wvfg_top.v ----
// wide vector feature gating: feature reporting and encoding gating
`timescale 1ns/1ps
`include "wvfg_map.vh"
module wvfg_top #(
	parameter HAS_ER   = 1'b0,
	parameter HAS_PF   = 1'b0,
	parameter HAS_FP16 = 1'b1
) (
	// clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// axi4-lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// decoded prefixed instruction
	input  wire        dec_valid,
	input  wire        dec_write_intent_pf,
	input  wire        dec_mask_op,
	input  wire        dec_mask_src_vec,
	input  wire [1:0]  vector_length_field,
	input  wire [2:0]  dec_group,
	input  wire        dec_only_256,
	input  wire        dec_privileged,
	// gating results
	output reg  [5:0]  usable_512_q,
	output reg  [5:0]  usable_short_q,
	output reg         os_state_ok_q,
	output reg         save_instrs_ok_q,
	output reg         dec_accept_q,
	output reg  [9:0]  dec_len_q,
	output reg  [3:0]  mask_reg_count_q,
	output reg  [9:0]  vec_state_bits_q
);
	////////////////////////////////////////////////////////////////////////
	reg  [31:0] leaf7_q;
	reg  [31:0] leaf1_q;
	reg  [31:0] extended_state_enable_reg_q;
	reg  [1:0]  status_q;
	reg  [11:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_have_q;
	reg         w_have_q;

	wire        os_ok;
	wire [5:0]  u512;
	wire [5:0]  ushort;
	wire [9:0]  len_w;
	wire        len_ok;
	wire [31:0] leaf7_eff;
	wire [31:0] leaf1_eff;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		begin
			merge = {st[3] ? nw[31:24] : old[31:24],
				st[2] ? nw[23:16] : old[23:16],
				st[1] ? nw[15:8]  : old[15:8],
				st[0] ? nw[7:0]   : old[7:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reported feature words: fixed bits forced, others from software
	assign leaf7_eff = leaf7_q
		| (32'h1 << `WVFG_BIT_FOUND)
		| (32'h1 << `WVFG_BIT_VL)
		| (32'h1 << `WVFG_BIT_CD) | (32'h1 << `WVFG_BIT_DQ)
		| ((HAS_FP16 ? 32'h1 : 32'h0) << `WVFG_BIT_BW);
	// er and pf exist only if built in; software cannot fake them
	wire [31:0] leaf7_fix;
	assign leaf7_fix = (leaf7_eff
		& ~((32'h1 << `WVFG_BIT_ER) | (32'h1 << `WVFG_BIT_PF)))
		| ((HAS_ER ? 32'h1 : 32'h0) << `WVFG_BIT_ER)
		| ((HAS_PF ? 32'h1 : 32'h0) << `WVFG_BIT_PF);
	assign leaf1_eff = leaf1_q;

	wvfg_group_check u_group (
		.leaf7_word   (leaf7_fix),
		.leaf1_word   (leaf1_eff),
		.enable_word  (extended_state_enable_reg_q),
		.os_ok        (os_ok),
		.usable_512   (u512),
		.usable_short (ushort)
	);

	wvfg_len_check u_len (
		.len_field    (vector_length_field),
		.group_sel    (dec_group),
		.only_256     (dec_only_256),
		.usable_512   (usable_512_q),
		.usable_short (usable_short_q),
		.op_len       (len_w),
		.accept       (len_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// gating outputs, one clock behind inputs
	always @(posedge clock) begin
		if (!reset_n) begin
			usable_512_q     <= 6'h00;
			usable_short_q   <= 6'h00;
			os_state_ok_q    <= 1'b0;
			save_instrs_ok_q <= 1'b0;
			mask_reg_count_q <= 4'h0;
			vec_state_bits_q <= 10'h000;
		end else begin
			usable_512_q     <= u512;
			usable_short_q   <= ushort;
			os_state_ok_q    <= os_ok;
			save_instrs_ok_q <= leaf1_eff[`WVFG_BIT_OSSAVE];
			mask_reg_count_q <= `WVFG_NMASK;
			vec_state_bits_q <= `WVFG_VLEN;
		end
	end

	// decode verdict: registered one clock after dec_valid
	wire mask_bad;
	assign mask_bad = dec_mask_op & dec_mask_src_vec;
	always @(posedge clock) begin
		if (!reset_n) begin
			dec_accept_q <= 1'b0;
			dec_len_q    <= 10'h000;
		end else if (dec_valid) begin
			if (dec_write_intent_pf) begin
				// no os state or fp exception support needed
				dec_accept_q <= 1'b1;
				dec_len_q    <= 10'h000;
			end else begin
				dec_accept_q <= len_ok & ~mask_bad;
				dec_len_q    <= len_w;
			end
		end else begin
			dec_accept_q <= 1'b0;
			dec_len_q    <= 10'h000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data taken in either order
	wire        do_write;
	wire        wr_leaf7;
	wire        wr_leaf1;
	wire        wr_enable;
	wire        wr_status;
	wire        len_fault_ev;
	wire        priv_fault_ev;
	reg  [1:0]  bresp_d;

	// one response outstanding at most: a held pair waits for bvalid to drop
	assign do_write      = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_leaf7      = do_write & (awaddr_q == `WVFG_A_LEAF7);
	assign wr_leaf1      = do_write & (awaddr_q == `WVFG_A_LEAF1);
	assign wr_enable     = do_write & (awaddr_q == `WVFG_A_ENABLE);
	assign wr_status     = do_write & (awaddr_q == `WVFG_A_STATUS);
	assign len_fault_ev  = dec_valid & ~dec_write_intent_pf & ~len_ok;
	assign priv_fault_ev = wr_enable & ~dec_privileged;

	// response code for the held write address
	always @* begin
		bresp_d = 2'h0;
		case (awaddr_q)
		`WVFG_A_LEAF7, `WVFG_A_LEAF1, `WVFG_A_STATUS: begin
			bresp_d = 2'h0;
		end
		`WVFG_A_USABLE, `WVFG_A_DECODE: begin
			// read-only words: the write is dropped without an error
			bresp_d = 2'h0;
		end
		`WVFG_A_ENABLE: begin
			bresp_d = dec_privileged ? 2'h0 : 2'h2;
		end
		default: begin
			bresp_d = 2'h3;
		end
		endcase
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
		end else begin
			// ready is a one-cycle pulse, so each valid is taken once
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= bresp_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// feature words stay writable so software can model other parts
	always @(posedge clock) begin
		if (!reset_n) begin
			leaf7_q <= `WVFG_RST_LEAF7;
			leaf1_q <= `WVFG_RST_LEAF1;
		end else begin
			if (wr_leaf7) begin
				leaf7_q <= merge(leaf7_q, wdata_q, wstrb_q);
			end
			if (wr_leaf1) begin
				leaf1_q <= merge(leaf1_q, wdata_q, wstrb_q);
			end
		end
	end

	// enable register: only a privileged write lands, others are refused
	always @(posedge clock) begin
		if (!reset_n) begin
			extended_state_enable_reg_q <= `WVFG_RST_ENABLE;
		end else if (wr_enable & dec_privileged) begin
			extended_state_enable_reg_q <= merge(
				extended_state_enable_reg_q, wdata_q, wstrb_q);
		end
	end

	// sticky faults, write one to clear; a fault in the clearing cycle wins
	always @(posedge clock) begin
		if (!reset_n) begin
			status_q <= 2'h0;
		end else begin
			if (wr_status & wstrb_q[0]) begin
				status_q <= status_q & ~wdata_q[1:0];
			end
			if (priv_fault_ev) begin
				status_q[`WVFG_ST_PRIV_FAULT] <= 1'b1;
			end
			if (len_fault_ev) begin
				status_q[`WVFG_ST_LEN_FAULT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read: data chosen from the address while arvalid stands
	reg  [31:0] rdata_d;
	reg  [1:0]  rresp_d;

	always @* begin
		rdata_d = 32'h00000000;
		rresp_d = 2'h0;
		case (s_axi_araddr)
		`WVFG_A_LEAF7: begin
			rdata_d = leaf7_fix;
		end
		`WVFG_A_LEAF1: begin
			rdata_d = leaf1_eff;
		end
		`WVFG_A_ENABLE: begin
			rdata_d = extended_state_enable_reg_q;
		end
		`WVFG_A_USABLE: begin
			rdata_d = {18'h0, usable_short_q, save_instrs_ok_q,
				os_state_ok_q, usable_512_q};
		end
		`WVFG_A_DECODE: begin
			rdata_d = {21'h0, dec_accept_q, dec_len_q};
		end
		`WVFG_A_STATUS: begin
			rdata_d = {30'h0, status_q};
		end
		default: begin
			rdata_d = 32'h00000000;
			rresp_d = 2'h3;
		end
		endcase
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else begin
			// no new address while read data still waits for rready
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdata_d;
				s_axi_rresp  <= rresp_d;
			end
		end
	end
endmodule

// ---- wvfg_map.vh ----
// constants for the wide vector feature gating block
`ifndef WVFG_MAP_VH
`define WVFG_MAP_VH
// feature bits, leaf 7 subleaf 0 second result word
`define WVFG_BIT_FOUND      16
`define WVFG_BIT_DQ         17
`define WVFG_BIT_PF         26
`define WVFG_BIT_ER         27
`define WVFG_BIT_CD         28
`define WVFG_BIT_BW         30
`define WVFG_BIT_VL         31
// leaf 1 third result word
`define WVFG_BIT_OSSAVE     27
// enable register fields
`define WVFG_EN_HI_MSB      7
`define WVFG_EN_HI_LSB      5
`define WVFG_EN_LO_MSB      2
`define WVFG_EN_LO_LSB      1
`define WVFG_EN_HI_ALL      3'h7
`define WVFG_EN_LO_ALL      2'h3
// vector length field codes
`define WVFG_LEN_128        2'h0
`define WVFG_LEN_256        2'h1
`define WVFG_LEN_512        2'h2
// group indexes for usable vector
`define WVFG_G_FOUND        0
`define WVFG_G_ER           1
`define WVFG_G_PF           2
`define WVFG_G_CD           3
`define WVFG_G_DQ           4
`define WVFG_G_BW           5
`define WVFG_NGROUPS        6
// register file sizes
`define WVFG_NMASK          4'h8
`define WVFG_VLEN           10'h200
// axi register offsets
`define WVFG_A_LEAF7        12'h000
`define WVFG_A_LEAF1        12'h004
`define WVFG_A_ENABLE       12'h008
`define WVFG_A_USABLE       12'h00C
`define WVFG_A_DECODE       12'h010
`define WVFG_A_STATUS       12'h014
// reset values
`define WVFG_RST_LEAF7      32'hC4030000
`define WVFG_RST_LEAF1      32'h00000000
`define WVFG_RST_ENABLE     32'h00000000
// status bits
`define WVFG_ST_PRIV_FAULT  0
`define WVFG_ST_LEN_FAULT   1
`endif

// ---- wvfg_group_check.v ----
// usable-group evaluation from feature words and os state
`timescale 1ns/1ps
`include "wvfg_map.vh"
module wvfg_group_check (
	// feature inputs
	input  wire [31:0] leaf7_word,
	input  wire [31:0] leaf1_word,
	input  wire [31:0] enable_word,
	// results
	output wire        os_ok,
	output wire [5:0]  usable_512,
	output wire [5:0]  usable_short
);
	wire found;
	wire vl;
	wire [5:0] own;

	// os checks: save flag, upper state bits and low state bits
	assign os_ok = leaf1_word[`WVFG_BIT_OSSAVE] &
		(enable_word[`WVFG_EN_HI_MSB:`WVFG_EN_HI_LSB] == `WVFG_EN_HI_ALL) &
		(enable_word[`WVFG_EN_LO_MSB:`WVFG_EN_LO_LSB] == `WVFG_EN_LO_ALL);
	assign found = leaf7_word[`WVFG_BIT_FOUND];
	assign vl    = leaf7_word[`WVFG_BIT_VL];
	assign own   = {leaf7_word[`WVFG_BIT_BW], leaf7_word[`WVFG_BIT_DQ],
		leaf7_word[`WVFG_BIT_CD], leaf7_word[`WVFG_BIT_PF],
		leaf7_word[`WVFG_BIT_ER], found};
	// sibling groups need the foundation bit too
	assign usable_512 = {6{os_ok & found}} & own;
	// shorter lengths: foundation, own bit and length bit all set; never for the er or pf group
	assign usable_short = {6{vl}} & usable_512 & 6'h39;
endmodule

// ---- wvfg_len_check.v ----
// vector length decode and 128-bit rejection for 256-only forms
`timescale 1ns/1ps
`include "wvfg_map.vh"
module wvfg_len_check (
	// decoded instruction
	input  wire [1:0]  len_field,
	input  wire [2:0]  group_sel,
	input  wire        only_256,
	// gating
	input  wire [5:0]  usable_512,
	input  wire [5:0]  usable_short,
	// results
	output wire [9:0]  op_len,
	output wire        accept
);
	function grp_bit;
		input [5:0] v;
		input [2:0] s;
		begin
			grp_bit = (s < 3'h6) ? v[s] : 1'b0;
		end
	endfunction

	reg [9:0] len_r;
	reg       ok_r;

	always @* begin
		len_r = 10'h000;
		ok_r  = 1'b0;
		case (len_field)
		`WVFG_LEN_512: begin
			len_r = 10'h200;
			ok_r  = grp_bit(usable_512, group_sel);
		end
		`WVFG_LEN_256: begin
			len_r = 10'h100;
			ok_r  = grp_bit(usable_short, group_sel);
		end
		`WVFG_LEN_128: begin
			len_r = 10'h080;
			// 256-only forms have no 128-bit encoding
			ok_r  = grp_bit(usable_short, group_sel) & ~only_256;
		end
		default: begin
			len_r = 10'h000;
			ok_r  = 1'b0;
		end
		endcase
	end
	assign op_len = len_r;
	assign accept = ok_r;
endmodule

// ---- wvfg_sw_model.sv ----
// software detection model: which groups a program may use
`timescale 1ns/1ps
module wvfg_sw_model (
	// feature words as software reads them
	input logic [31:0] leaf7,
	input logic [31:0] leaf1,
	input logic [31:0] enable,
	// verdicts
	output logic       os_ok,
	output logic [5:0] use_512,
	output logic [5:0] use_short
);
	logic [5:0] own;
	assign os_ok = leaf1[27] && enable[7:5] == 3'h7 && enable[2:1] == 2'h3;
	// group order: bw dq cd pf er foundation
	assign own = {leaf7[30], leaf7[17], leaf7[28], leaf7[26], leaf7[27],
		leaf7[16]};
	assign use_512 = (os_ok && leaf7[16]) ? own : 6'h00;
	// the length flag alone never opens a group
	assign use_short = (os_ok && leaf7[16] && leaf7[31]) ? (own & 6'h39)
		: 6'h00;
endmodule

// ---- wvfg_top_asserts.sv ----
// assertion checker for the feature gating top
`timescale 1ns/1ps
module wvfg_chk (
	// clock and reset
	input logic       clock,
	input logic       reset_n,
	// decode side
	input logic       dec_valid,
	input logic       dec_write_intent_pf,
	input logic       dec_mask_op,
	input logic       dec_mask_src_vec,
	input logic [1:0] vector_length_field,
	input logic       dec_only_256,
	// results
	input logic [5:0] usable_512_q,
	input logic [5:0] usable_short_q,
	input logic       os_state_ok_q,
	input logic       save_instrs_ok_q,
	input logic       dec_accept_q,
	input logic [9:0] dec_len_q,
	input logic [3:0] mask_reg_count_q,
	input logic [9:0] vec_state_bits_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	AST_PF_OK: assert property (dec_valid && dec_write_intent_pf |=>
		dec_accept_q) else $error("prefetch refused");
	AST_NO_128: assert property (dec_valid && !dec_write_intent_pf &&
		dec_only_256 && vector_length_field == 2'h0 |=> !dec_accept_q)
		else $error("128 form accepted");
	AST_LEN_256: assert property (dec_valid && !dec_write_intent_pf &&
		vector_length_field == 2'h1 |=> !dec_accept_q ||
		dec_len_q == 10'h100) else $error("wrong length");
	AST_MASK_SRC: assert property (dec_valid && !dec_write_intent_pf &&
		dec_mask_op && dec_mask_src_vec |=> !dec_accept_q)
		else $error("mask op with vector source");
	AST_OS_GATE: assert property (!os_state_ok_q |->
		usable_512_q == 6'h00 && usable_short_q == 6'h00)
		else $error("usable without os state");
	AST_SHORT: assert property ((usable_short_q & ~usable_512_q) == 6'h00 &&
		usable_short_q[2:1] == 2'h0) else $error("short length leak");
	AST_FOUND: assert property (|usable_512_q[5:1] |-> usable_512_q[0])
		else $error("group without foundation");
	AST_SAVE: assert property (os_state_ok_q |-> save_instrs_ok_q)
		else $error("save instrs off");
	AST_RST: assert property ($rose(reset_n) |-> usable_512_q == 6'h00 &&
		usable_short_q == 6'h00) else $error("usable after reset");
	AST_STATE: assert property (reset_n && $past(reset_n) |->
		mask_reg_count_q == 4'h8 && vec_state_bits_q == 10'h200)
		else $error("state size wrong");
endmodule
////////////////////////////////////////////////////////////////////////
bind wvfg_top wvfg_chk i_chk (.clock(clock), .reset_n(reset_n),
	.dec_valid(dec_valid), .dec_write_intent_pf(dec_write_intent_pf),
	.dec_mask_op(dec_mask_op), .dec_mask_src_vec(dec_mask_src_vec),
	.vector_length_field(vector_length_field), .dec_only_256(dec_only_256),
	.usable_512_q(usable_512_q), .usable_short_q(usable_short_q),
	.os_state_ok_q(os_state_ok_q), .save_instrs_ok_q(save_instrs_ok_q),
	.dec_accept_q(dec_accept_q), .dec_len_q(dec_len_q),
	.mask_reg_count_q(mask_reg_count_q), .vec_state_bits_q(vec_state_bits_q));

// ---- wvfg_top_bench.sv ----
// self-checking bench for the feature gating top
`timescale 1ns/1ps
module wvfg_top_bench;
	logic        clock = 1'h0, reset_n = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, leaf1_v = 32'h0, en_v = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF, mask_reg_count_q;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, vector_length_field = 2'h0;
	logic        dec_valid = 1'h0, dec_write_intent_pf = 1'h0, dec_mask_op = 1'h0;
	logic        dec_mask_src_vec = 1'h0, dec_only_256 = 1'h0;
	logic        dec_privileged = 1'h0, os_state_ok_q, save_instrs_ok_q;
	logic        dec_accept_q, eos, ea;
	logic [2:0]  dec_group = 3'h0;
	logic [5:0]  usable_512_q, usable_short_q, e512, eshort;
	logic [9:0]  dec_len_q, vec_state_bits_q;
	int          err_count = 0, num_checks = 0, cyc = 0;

	wvfg_top #(.HAS_ER(1'b0), .HAS_PF(1'b0), .HAS_FP16(1'b1)) i_dut (.*);
	wvfg_sw_model i_sw (.leaf7(32'hD0030000), .leaf1(leaf1_v), .enable(en_v),
		.os_ok(eos), .use_512(e512), .use_short(eshort));

	always #4 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			close_out;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, ed,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", ed, s_axi_rdata & m);
		chk("rresp", er, s_axi_rresp);
	endtask
	// privileged writes of save flag and enable word, then one clock
	task automatic gate(input logic [31:0] l1, en);
		leaf1_v = l1;
		en_v = en;
		dec_privileged <= 1'b1;
		wr(12'h004, l1, 2'h0);
		wr(12'h008, en, 2'h0);
		@(posedge clock);
		#1;
		chk("os", eos, os_state_ok_q);
		chk("save", l1[27], save_instrs_ok_q);
		chk("u512", e512, usable_512_q);
		chk("ushort", eshort, usable_short_q);
	endtask
	task automatic dec(input logic [2:0] g, input logic [1:0] l,
		input logic o, pf, mv, e);
		@(posedge clock);
		dec_valid <= 1'b1;
		dec_group <= g;
		vector_length_field <= l;
		dec_only_256 <= o;
		dec_write_intent_pf <= pf;
		dec_mask_op <= mv;
		dec_mask_src_vec <= mv;
		@(posedge clock);
		dec_valid <= 1'b0;
		#1;
		chk("accept", e, dec_accept_q);
		if (e && !pf) chk("len", 10'h080 << l, dec_len_q);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		rd(12'h000, 32'hD0030000, 32'hD0030000, 2'h0);
		chk("masks", 4'h8, mask_reg_count_q);
		chk("vbits", 10'h200, vec_state_bits_q);
		chk("u512", 6'h00, usable_512_q);
		rd(12'h020, 32'hFFFFFFFF, 32'h0, 2'h3);
		$display("test reset done");
		gate(32'h08000000, 32'h000000C6);
		gate(32'h08000000, 32'h000000E4);
		gate(32'h00000000, 32'h000000E6);
		gate(32'h08000000, 32'h000000E6);
		rd(12'h004, 32'h08000000, 32'h08000000, 2'h0);
		rd(12'h00C, 32'hFFFFFFFF, 32'h000039F9, 2'h0);
		dec_privileged <= 1'b0;
		wr(12'h008, 32'h0, 2'h2);
		rd(12'h008, 32'hFFFFFFFF, 32'h000000E6, 2'h0);
		$display("test gating done");
		for (int k = 0; k < 64; k++) begin
			ea = k[5:3] < 3'h6 && k[2:1] != 2'h3 && !(k[0] && k[2:1] == 2'h0)
				&& (k[2:1] == 2'h2 ? e512[k[5:3]] : eshort[k[5:3]]);
			dec(k[5:3], k[2:1], k[0], 1'b0, 1'b0, ea);
		end
		dec(3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
		rd(12'h014, 32'h00000003, 32'h00000003, 2'h0);
		wr(12'h014, 32'h00000003, 2'h0);
		rd(12'h014, 32'h00000003, 32'h00000000, 2'h0);
		gate(32'h0, 32'h0);
		dec(3'h0, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
		dec(3'h0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test decode done");
		close_out;
	end
endmodule
